// *** rtl/uhb_regs.svh ***
// Register offsets, field positions and reset values of the serial block.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef UHB_REGS_SVH
`define UHB_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB).
`define UHB_OFF_CTRL   8'h00
`define UHB_OFF_BAUD   8'h04
`define UHB_OFF_THR    8'h08
`define UHB_OFF_RXD    8'h0c
`define UHB_OFF_STAT   8'h10

// ==========================================================================
// Control fields.
`define UHB_CTRL_TXEN  0
`define UHB_CTRL_RXEN  1
`define UHB_CTRL_HSK   2
`define UHB_CTRL_RST   3'h0

// ==========================================================================
// Status fields.
`define UHB_ST_TX_READY 0
`define UHB_ST_TXEMP   1
`define UHB_ST_RXRDY   2
`define UHB_ST_FRERR   3
`define UHB_ST_BRK     4
`define UHB_ST_OVR     5
`define UHB_ST_CTS     6
`define UHB_ST_DCD     7

// ==========================================================================
// Reset values and small constants.
`define UHB_BAUD_RST   16'h000f
`define UHB_LAST_BIT   3'h7
`define UHB_ZERO32     32'h0000_0000
`define UHB_PINS_RST   3'h6
`define UHB_FLAGS_RST  4'h0
`define UHB_CNT_ONE    16'h0001
`define UHB_IDX_ONE    3'h1

`endif

// *** rtl/uhb_pkg.sv ***
// Types shared by the serial block: state encodings and signal groups.
// Assumes the register header is on the include path.
package uhb_pkg;

  // ========================================================================
  // Transmitter states.
  typedef enum logic [1:0] {
    UHB_TX_IDLE  = 2'b00,
    UHB_TX_START = 2'b01,
    UHB_TX_DATA  = 2'b10,
    UHB_TX_STOP  = 2'b11
  } uhb_tx_st_t;

  // ========================================================================
  // Receiver states.
  typedef enum logic [2:0] {
    UHB_RX_IDLE  = 3'b000,
    UHB_RX_START = 3'b001,
    UHB_RX_DATA  = 3'b010,
    UHB_RX_STOP  = 3'b011,
    UHB_RX_WAITH = 3'b100
  } uhb_rx_st_t;

  // Pins that cross into the clock domain.
  typedef struct packed {
    logic cts;  // Clear to send, high means stop.
    logic rxd;  // Receive line, idle high.
    logic dcd;  // Carrier detect as sensed, high means asserted.
  } uhb_pins_t;

  // Sticky receiver flags.
  typedef struct packed {
    logic ovr;
    logic brk;
    logic frerr;
    logic rxrdy;
  } uhb_rxflags_t;

endpackage

// *** rtl/uhb_usart.sv ***
// Asynchronous serial transmitter and receiver with an APB register file.
// Assumes one clock pclk, pins asynchronous to it, and an APB master.
//
// How it works
// [R1] Start committed only while clear-to-send is low, a held character aside.
// [R2] Peer keeps clear-to-send steady around start.
// [R3] Held character still sent after clear-to-send rises.
// [R4] Software writes holding register only when ready.
// [R5] Carrier detect sensed as asserted when high.
// [R6] Board inverts carrier detect for low-active intent.
// [R7] Break missed after back-to-back characters, framing instead.
// [R8] Peer adds timeguard or second stop bit.
// [R9] Break armed only after one idle bit time.
// [R10] Low stop gives framing error; all-low gives break once armed.
`include "uhb_regs.svh"

module uhb_usart
  import uhb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             txd,
  input  wire logic        cts_pin,
  input  wire logic        rxd_pin,
  input  wire logic        dcd_pin
);

  // ========================================================================
  // Declarations.
  uhb_pins_t    s1_q, s2_q;            // Two-stage pin synchronisers.
  logic         pready_q, pready_d;    // Registered APB ready.
  logic         pslverr_q, pslverr_d;  // Registered APB error.
  logic [31:0]  prdata_q, prdata_d;    // Registered APB read data.
  logic [2:0]   ctrl_q, ctrl_d;        // Enables and handshake mode.
  logic [15:0]  baud_q, baud_d;        // Bit period minus one.
  logic         apb_hit, wr_done, rd_done, mapped;
  uhb_tx_st_t   tx_st_q, tx_st_d;
  logic [15:0]  tx_cnt_q, tx_cnt_d;
  logic [2:0]   tx_idx_q, tx_idx_d;
  logic [7:0]   tx_sh_q, tx_sh_d;
  logic [7:0]   thr_q, thr_d;          // Transmit holding register.
  logic         thr_full_q, thr_full_d;
  logic         held_q, held_d;        // Held char goes out despite stop.
  logic         cts_seen_q, cts_seen_d; // Handshake stop one cycle ago.
  logic         txd_q, txd_d;
  logic         cts_stop;
  uhb_rx_st_t   rx_st_q, rx_st_d;
  logic [15:0]  rx_cnt_q, rx_cnt_d;
  logic [2:0]   rx_idx_q, rx_idx_d;
  logic [7:0]   rx_sh_q, rx_sh_d;
  logic [7:0]   rx_data_q, rx_data_d;
  logic         armed_q, armed_d;      // Break detection armed.
  logic         allzero_q, allzero_d;  // Every sample so far was low.
  uhb_rxflags_t fl_q, fl_d;
  uhb_rxflags_t fl_set, fl_clr;

  // True when a bit period has elapsed.
  function automatic logic bit_tick(input logic [15:0] c,
                                    input logic [15:0] d);
    return c == d;
  endfunction

  // ========================================================================
  // Pin synchronisers; nothing reads the first stage but the second.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= `UHB_PINS_RST;
      s2_q <= `UHB_PINS_RST;
    end
    else
    begin
      s1_q <= '{cts: cts_pin, rxd: rxd_pin, dcd: dcd_pin};
      s2_q <= s1_q;
    end
  end

  // ========================================================================
  // APB slave. One wait state so that every answer comes from a flop.
  assign apb_hit = psel & penable & ~pready_q;
  assign wr_done = psel & penable & pready_q & pwrite;
  assign rd_done = psel & penable & pready_q & ~pwrite;

  // Decode, read mux and control register writes.
  always_comb
  begin
    prdata_d = `UHB_ZERO32;
    mapped   = 1'b1;
    ctrl_d   = ctrl_q;
    baud_d   = baud_q;
    if (paddr == `UHB_OFF_CTRL)
    begin
      prdata_d[2:0] = ctrl_q;
      if (wr_done) ctrl_d = pwdata[2:0];
    end
    else if (paddr == `UHB_OFF_BAUD)
    begin
      prdata_d[15:0] = baud_q;
      if (wr_done) baud_d = pwdata[15:0];
    end
    else if (paddr == `UHB_OFF_THR)
    begin
      // Write only; reads return zero.
    end
    else if (paddr == `UHB_OFF_RXD)
    begin
      prdata_d[7:0] = rx_data_q;
    end
    else if (paddr == `UHB_OFF_STAT)
    begin
      prdata_d[`UHB_ST_TX_READY] = ~thr_full_q;
      prdata_d[`UHB_ST_TXEMP] = ~thr_full_q & (tx_st_q == UHB_TX_IDLE);
      prdata_d[`UHB_ST_RXRDY] = fl_q.rxrdy;
      prdata_d[`UHB_ST_FRERR] = fl_q.frerr;
      prdata_d[`UHB_ST_BRK]   = fl_q.brk;
      prdata_d[`UHB_ST_OVR]   = fl_q.ovr;
      prdata_d[`UHB_ST_CTS]   = s2_q.cts;
      // Carrier shown as sensed: high on the pin reads as asserted.
      prdata_d[`UHB_ST_DCD]   = s2_q.dcd; // [R5] [R6]
    end
    else
    begin
      mapped = 1'b0;
    end
    if (!apb_hit) prdata_d = `UHB_ZERO32;
    pready_d  = apb_hit;
    pslverr_d = apb_hit & ~mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `UHB_ZERO32;
      ctrl_q    <= `UHB_CTRL_RST;
      baud_q    <= `UHB_BAUD_RST;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      ctrl_q    <= ctrl_d;
      baud_q    <= baud_d;
    end
  end

  // ========================================================================
  // Transmitter. Clear-to-send only gates the next start bit, so a
  // rise during the start bit can never cut a character short.
  assign cts_stop = ctrl_q[`UHB_CTRL_HSK] & s2_q.cts; // [R2]

  always_comb
  begin
    tx_st_d    = tx_st_q;
    tx_cnt_d   = tx_cnt_q + `UHB_CNT_ONE;
    tx_idx_d   = tx_idx_q;
    tx_sh_d    = tx_sh_q;
    thr_d      = thr_q;
    thr_full_d = thr_full_q;
    held_d     = held_q;
    cts_seen_d = cts_stop;
    // A write while full is dropped; software waits for the ready flag.
    if (wr_done && paddr == `UHB_OFF_THR && !thr_full_q) // [R4]
    begin
      thr_d      = pwdata[7:0];
      thr_full_d = 1'b1;
    end
    // Stop rising mid-character with a held one: that one still goes out.
    // Only the rise counts, so a character written after it must wait.
    if (tx_st_q != UHB_TX_IDLE && cts_stop && !cts_seen_q && thr_full_q)
      held_d = 1'b1; // [R3]
    case (tx_st_q)
      UHB_TX_IDLE:
      begin
        tx_cnt_d = '0;
        if (ctrl_q[`UHB_CTRL_TXEN] && thr_full_q && !cts_stop) // [R1]
        begin
          tx_sh_d    = thr_q;
          thr_full_d = 1'b0;
          held_d     = 1'b0;
          tx_st_d    = UHB_TX_START;
        end
      end
      UHB_TX_START:
        if (bit_tick(tx_cnt_q, baud_q))
        begin
          tx_cnt_d = '0;
          tx_idx_d = '0;
          tx_st_d  = UHB_TX_DATA;
        end
      UHB_TX_DATA:
        if (bit_tick(tx_cnt_q, baud_q))
        begin
          tx_cnt_d = '0;
          tx_idx_d = tx_idx_q + `UHB_IDX_ONE;
          if (tx_idx_q == `UHB_LAST_BIT) tx_st_d = UHB_TX_STOP;
        end
      default:
        if (bit_tick(tx_cnt_q, baud_q))
        begin
          tx_cnt_d = '0;
          tx_st_d  = UHB_TX_IDLE;
          if (ctrl_q[`UHB_CTRL_TXEN] && thr_full_q &&
              (!cts_stop || held_d)) // [R3]
          begin
            tx_sh_d    = thr_q;
            thr_full_d = 1'b0;
            held_d     = 1'b0;
            tx_st_d    = UHB_TX_START;
          end
        end
    endcase
    // Line level follows the next state so that txd is a plain flop.
    if (tx_st_d == UHB_TX_START)     txd_d = 1'b0;
    else if (tx_st_d == UHB_TX_DATA) txd_d = tx_sh_d[tx_idx_d];
    else                             txd_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q    <= UHB_TX_IDLE;
      tx_cnt_q   <= '0;
      tx_idx_q   <= '0;
      tx_sh_q    <= '0;
      thr_q      <= '0;
      thr_full_q <= 1'b0;
      held_q     <= 1'b0;
      cts_seen_q <= 1'b0;
      txd_q      <= 1'b1;
    end
    else
    begin
      tx_st_q    <= tx_st_d;
      tx_cnt_q   <= tx_cnt_d;
      tx_idx_q   <= tx_idx_d;
      tx_sh_q    <= tx_sh_d;
      thr_q      <= thr_d;
      thr_full_q <= thr_full_d;
      held_q     <= held_d;
      cts_seen_q <= cts_seen_d;
      txd_q      <= txd_d;
    end
  end

  // ========================================================================
  // Receiver. Only one stop bit is checked; break needs a further idle bit
  // time to arm, so a break right after a back-to-back pair is missed.
  always_comb
  begin
    rx_st_d   = rx_st_q;
    rx_cnt_d  = rx_cnt_q + `UHB_CNT_ONE;
    rx_idx_d  = rx_idx_q;
    rx_sh_d   = rx_sh_q;
    rx_data_d = rx_data_q;
    armed_d   = armed_q;
    allzero_d = allzero_q;
    fl_set    = `UHB_FLAGS_RST;
    fl_clr    = `UHB_FLAGS_RST;
    case (rx_st_q)
      UHB_RX_IDLE:
        if (!s2_q.rxd && ctrl_q[`UHB_CTRL_RXEN])
        begin
          rx_cnt_d = '0;
          rx_st_d  = UHB_RX_START;
        end
        else if (bit_tick(rx_cnt_q, baud_q))
        begin
          rx_cnt_d = rx_cnt_q;
          armed_d  = 1'b1; // [R9] [R8]
        end
      UHB_RX_START:
        if (rx_cnt_q == (baud_q >> 1))
        begin
          rx_cnt_d  = '0;
          rx_idx_d  = '0;
          allzero_d = 1'b1;
          rx_st_d   = s2_q.rxd ? UHB_RX_IDLE : UHB_RX_DATA;
        end
      UHB_RX_DATA:
        if (bit_tick(rx_cnt_q, baud_q))
        begin
          rx_cnt_d  = '0;
          rx_sh_d   = {s2_q.rxd, rx_sh_q[7:1]};
          allzero_d = allzero_q & ~s2_q.rxd;
          rx_idx_d  = rx_idx_q + `UHB_IDX_ONE;
          if (rx_idx_q == `UHB_LAST_BIT) rx_st_d = UHB_RX_STOP;
        end
      UHB_RX_STOP:
        if (bit_tick(rx_cnt_q, baud_q))
        begin
          rx_cnt_d = '0;
          armed_d  = 1'b0;
          rx_st_d  = UHB_RX_WAITH;
          if (s2_q.rxd)
          begin
            rx_data_d    = rx_sh_q;
            fl_set.rxrdy = 1'b1;
            fl_set.ovr   = fl_q.rxrdy;
          end
          else if (allzero_q && armed_q)
            fl_set.brk = 1'b1; // [R10]
          else
            fl_set.frerr = 1'b1; // [R7] [R10]
        end
      default:
      begin
        // Hold off until the line is high again after a low stop bit.
        rx_cnt_d = '0;
        if (s2_q.rxd) rx_st_d = UHB_RX_IDLE;
      end
    endcase
    // Software clears: reading data drops ready, error bits are W1C.
    fl_clr.rxrdy = rd_done && paddr == `UHB_OFF_RXD;
    if (wr_done && paddr == `UHB_OFF_STAT)
    begin
      fl_clr.frerr = pwdata[`UHB_ST_FRERR];
      fl_clr.brk   = pwdata[`UHB_ST_BRK];
      fl_clr.ovr   = pwdata[`UHB_ST_OVR];
    end
    // A set in the clearing cycle wins.
    fl_d = (fl_q & ~fl_clr) | fl_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q   <= UHB_RX_IDLE;
      rx_cnt_q  <= '0;
      rx_idx_q  <= '0;
      rx_sh_q   <= '0;
      rx_data_q <= '0;
      armed_q   <= 1'b0;
      allzero_q <= 1'b0;
      fl_q      <= `UHB_FLAGS_RST;
    end
    else
    begin
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_idx_q  <= rx_idx_d;
      rx_sh_q   <= rx_sh_d;
      rx_data_q <= rx_data_d;
      armed_q   <= armed_d;
      allzero_q <= allzero_d;
      fl_q      <= fl_d;
    end
  end

  // ========================================================================
  // Outputs.
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign txd     = txd_q;

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_CTS_OK: assert property ( // [R1]
    (tx_st_q == UHB_TX_IDLE) ##1 (tx_st_q == UHB_TX_START)
      |-> $past(!cts_stop))
    else $error("Start bit began while clear-to-send was high.");

  AST_NO_ABORT: assert property ( // [R1]
    (tx_st_q == UHB_TX_START) && cts_stop |=> tx_st_q != UHB_TX_IDLE)
    else $error("Character abandoned after its start bit.");

  AST_HELD_SENT: assert property ( // [R3]
    (tx_st_q == UHB_TX_STOP) && held_q && thr_full_q &&
    ctrl_q[`UHB_CTRL_TXEN] && bit_tick(tx_cnt_q, baud_q)
      |=> (tx_st_q == UHB_TX_START) && !txd_q)
    else $error("Held character not sent after clear-to-send rose.");

  AST_CARRIER_HIGH: assert property ( // [R5]
    apb_hit && !pwrite && paddr == `UHB_OFF_STAT
      |=> prdata_q[`UHB_ST_DCD] == $past(s2_q.dcd))
    else $error("Carrier detect status does not follow the pin.");

  AST_BRK_ARMED: assert property ( // [R7]
    $rose(fl_q.brk) |-> $past(armed_q))
    else $error("Break flagged without armed detection.");

  AST_B2B_FRERR: assert property ( // [R7]
    (rx_st_q == UHB_RX_STOP) && bit_tick(rx_cnt_q, baud_q) &&
    !s2_q.rxd && !armed_q
      |=> fl_q.frerr && !$rose(fl_q.brk))
    else $error("Unarmed low stop bit did not give framing error.");

  AST_DETECT_ON_IN_IDLE: assert property ( // [R9]
    $rose(armed_q) |-> $past(rx_st_q) == UHB_RX_IDLE)
    else $error("Break detection armed outside idle.");

  AST_STOP_LOW: assert property ( // [R10]
    (rx_st_q == UHB_RX_STOP) && bit_tick(rx_cnt_q, baud_q) &&
    !s2_q.rxd |=> fl_q.frerr || fl_q.brk)
    else $error("Low stop bit left no error flag.");

  AST_PREADY_PULSE: assert property (
    pready_q |=> !pready_q)
    else $error("Ready held for more than one cycle.");

endmodule // uhb_usart

// *** bench/uhb_peer.sv ***
// Remote serial peer: an 8N1 sender onto the receive line, a catcher of the
// transmit line, and the modem lines clear-to-send and carrier detect.
// Assumes BIT_CYC equals the programmed bit period in pclk cycles.
module uhb_peer #(
  parameter int BIT_CYC = 12  // Bit period in clock cycles.
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd_pin,
  output logic      cts_pin,
  output logic      dcd_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Line state.
  logic [8:0] got[$];      // Caught characters, stop bit on top.
  logic [8:0] sh;          // Shift register of the catcher.
  logic       carrier_on;  // Modem carrier present.
  logic       dcd_n;       // Modem output, low while carrier present.

  // The modem drives carrier detect low-active; the board inverter makes
  // the pin read high, which is the level the receiving silicon senses.
  assign dcd_n   = ~carrier_on;
  assign dcd_pin = ~dcd_n;

  // Lines start idle: no stop request, no carrier, receive line high.
  initial
  begin
    rxd_pin    = 1'b1;
    cts_pin    = 1'b0;
    carrier_on = 1'b0;
  end

  // Modem lines change just after a clock edge; the caller picks the moment.
  task automatic set_lines(input logic cts, input logic car);
    @(posedge pclk);
    cts_pin    <= cts;
    carrier_on <= car;
  endtask

  // One frame LSB first; a low stop with zero data makes a break.
  // The idle gap afterwards is the timeguard the receiver needs.
  task automatic send(input logic [7:0] d, input logic stp, input int gap);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      rxd_pin <= f[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd_pin <= 1'b1;
    repeat (gap * BIT_CYC) @(posedge pclk);
  endtask

  // Catcher: samples every data bit in its middle, stop bit included.
  always
  begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CYC) @(posedge pclk);
      sh = {txd, sh[8:1]};
    end
    got.push_back(sh);
  end
endmodule // uhb_peer

// *** bench/tb_uhb_usart.sv ***
// Self-checking bench of the serial block: APB register tasks and a peer.
// Assumes the register header and package are compiled ahead of it.
`include "uhb_regs.svh"

module tb_uhb_usart;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and counters.
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, txd, cts_pin, rxd_pin, dcd_pin;
  int          miscompares = 0;  // Mismatches seen.
  int          compares    = 0;  // Comparisons made.

  uhb_usart i_uhb_usart (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .cts_pin(cts_pin), .rxd_pin(rxd_pin), .dcd_pin(dcd_pin));

  uhb_peer #(.BIT_CYC(12)) i_uhb_peer (.pclk(pclk), .txd(txd),
    .rxd_pin(rxd_pin), .cts_pin(cts_pin), .dcd_pin(dcd_pin));

  // 20 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========================================================================
  // Verdict, compare and bus tasks.
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is sampled high, bounded wait.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  // Software polls the ready flag before each holding-register write.
  task automatic wr_thr(input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    int          k;
    k = 0;
    do
    begin
      apb(1'b0, `UHB_OFF_STAT, 32'h0, r, e);
      k++;
    end
    while (r[`UHB_ST_TX_READY] !== 1'b1 && k < 100);
    chk({31'h0, r[`UHB_ST_TX_READY]}, 32'h1);
    if (r[`UHB_ST_TX_READY] !== 1'b1) give_verdict();
    wr(`UHB_OFF_THR, {24'h0, d});
  endtask

  // Waits, bounded, until the peer has caught n characters.
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (i_uhb_peer.got.size() < n && k < 1000)
    begin
      @(posedge pclk);
      k++;
    end
    chk(32'(i_uhb_peer.got.size()), 32'(n));
    if (i_uhb_peer.got.size() < n) give_verdict();
  endtask

  // ==========================================================================
  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`UHB_OFF_CTRL, 32'h0);
    rd(`UHB_OFF_BAUD, {16'h0, `UHB_BAUD_RST});
    rd(`UHB_OFF_STAT, 32'h03);
    rd(8'h14, 32'h0, 1'b1);
    wr(`UHB_OFF_BAUD, 32'hb);
    rd(`UHB_OFF_BAUD, 32'hb);
    wr(`UHB_OFF_CTRL, 32'h7);
    rd(`UHB_OFF_CTRL, 32'h7);
    // A held character still leaves once clear-to-send rises mid-frame;
    // the next one waits until the line is cleared again.
    wr_thr(8'ha5);
    wr_thr(8'h11);
    wr_thr(8'h22);
    repeat (40) @(posedge pclk);
    i_uhb_peer.set_lines(1'b1, 1'b0);
    wr_thr(8'h33);
    wait_rx(3);
    repeat (200) @(posedge pclk);
    chk(32'(i_uhb_peer.got.size()), 32'h3);
    rd(`UHB_OFF_STAT, 32'h40);
    i_uhb_peer.set_lines(1'b0, 1'b0);
    wait_rx(4);
    chk(32'(i_uhb_peer.got[0]), 32'h1a5);
    chk(32'(i_uhb_peer.got[1]), 32'h111);
    chk(32'(i_uhb_peer.got[2]), 32'h122);
    chk(32'(i_uhb_peer.got[3]), 32'h133);
    // Carrier present reads high in status.
    i_uhb_peer.set_lines(1'b0, 1'b1);
    repeat (20) @(posedge pclk);
    rd(`UHB_OFF_STAT, 32'h83);
    i_uhb_peer.set_lines(1'b0, 1'b0);
    // Receive with a timeguard, then a break after idle.
    i_uhb_peer.send(8'h5a, 1'b1, 2);
    rd(`UHB_OFF_STAT, 32'h07);
    rd(`UHB_OFF_RXD, 32'h5a);
    i_uhb_peer.send(8'h00, 1'b0, 3);
    rd(`UHB_OFF_STAT, 32'h13);
    wr(`UHB_OFF_STAT, 32'h38);
    rd(`UHB_OFF_STAT, 32'h03);
    // Break right behind a character is taken as a framing error.
    i_uhb_peer.send(8'h3c, 1'b1, 0);
    i_uhb_peer.send(8'h00, 1'b0, 3);
    rd(`UHB_OFF_STAT, 32'h0f);
    rd(`UHB_OFF_RXD, 32'h3c);
    // A second character before the first is read sets overrun.
    wr(`UHB_OFF_STAT, 32'h38);
    i_uhb_peer.send(8'h12, 1'b1, 2);
    i_uhb_peer.send(8'h34, 1'b1, 2);
    rd(`UHB_OFF_STAT, 32'h27);
    rd(`UHB_OFF_RXD, 32'h34);
    give_verdict();
  end
endmodule // tb_uhb_usart
